/* File: include/smwpp_defines.svh */
// Named constants of the SPI write-protect and array-write path
`ifndef SMWPP_DEFINES_SVH
`define SMWPP_DEFINES_SVH

// ==========================================================================
// Command codes
`define SMWPP_OP_SET_LATCH 8'h06
`define SMWPP_OP_CLEAR_LATCH 8'h04
`define SMWPP_OP_STATUS_READ 8'h05
`define SMWPP_OP_STATUS_WRITE 8'h01
`define SMWPP_OP_MEM_WRITE 8'h02

// ==========================================================================
// Array geometry
`define SMWPP_ADDR_W 18
`define SMWPP_DEPTH 262144
`define SMWPP_ADDR_FIRST 18'h00000
`define SMWPP_ADDR_LAST 18'h3FFFF
`define SMWPP_ADDR_ONE 18'h00001
`define SMWPP_QUARTER_BASE 18'h30000
`define SMWPP_HALF_BASE 18'h20000
`define SMWPP_ADDR_BYTE_LAST 2'h2

// ==========================================================================
// Status byte layout and block-protect codes
`define SMWPP_SR_PIN_EN 7
`define SMWPP_SR_BP_HI 3
`define SMWPP_SR_BP_LO 2
`define SMWPP_SR_FIXED 8'h40
`define SMWPP_BP_NONE 2'h0
`define SMWPP_BP_QUARTER 2'h1
`define SMWPP_BP_HALF 2'h2

// ==========================================================================
// Serial framing
`define SMWPP_BIT_FIRST 3'h0
`define SMWPP_BIT_LAST 3'h7

`endif

/* File: include/smwpp_pkg.sv */
// Types and shared decode functions of the SPI write-protect path
`include "smwpp_defines.svh"

package smwpp_pkg;

  // ========================================================================
  // Frame state, one-hot
  typedef enum logic [6:0] {
    s_cmd = 7'h01,
    s_addr = 7'h02,
    s_data = 7'h04,
    s_statw = 7'h08,
    s_status_read_cmd = 7'h10,
    s_done = 7'h20,
    s_ignore = 7'h40
  } smwpp_state_t;

  // ========================================================================
  // Decode
  function automatic smwpp_state_t smwpp_decode(input logic [7:0] op);
    smwpp_state_t st;
    st = s_ignore;
    if (op == `SMWPP_OP_SET_LATCH || op == `SMWPP_OP_CLEAR_LATCH)
      st = s_done;
    else if (op == `SMWPP_OP_STATUS_READ)
      st = s_status_read_cmd;
    else if (op == `SMWPP_OP_STATUS_WRITE)
      st = s_statw;
    else if (op == `SMWPP_OP_MEM_WRITE)
      st = s_addr;
    return st;
  endfunction : smwpp_decode

  function automatic logic smwpp_is_protected(input logic [1:0] bp, input logic [`SMWPP_ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b1;
    case (bp)
      `SMWPP_BP_NONE: hit = 1'b0;
      `SMWPP_BP_QUARTER: hit = (addr >= `SMWPP_QUARTER_BASE);
      `SMWPP_BP_HALF: hit = (addr >= `SMWPP_HALF_BASE);
      default: hit = 1'b1;
    endcase
    return hit;
  endfunction : smwpp_is_protected

endpackage : smwpp_pkg

/* File: hdl/smwpp_sync.sv */
// Two-flop level synchroniser
`timescale 1ns/1ps

module smwpp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Level in and out
  input wire logic d,
  output logic q
);

  logic stage1;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule : smwpp_sync

/* File: hdl/smwpp_ram.sv */
// Byte-wide array with one write port and a registered read port
`timescale 1ns/1ps
`include "smwpp_defines.svh"

module smwpp_ram (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write port
  input wire logic we,
  input wire logic [`SMWPP_ADDR_W-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read port
  input wire logic [`SMWPP_ADDR_W-1:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] cells [0:`SMWPP_DEPTH-1];

  always_ff @(posedge clk)
  begin
    if (we)
      cells[wr_addr] <= wr_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= 8'h00;
    else
      rd_data <= cells[rd_addr];
  end

endmodule : smwpp_ram

/* File: hdl/smwpp_top.sv */
// SPI slave status register, write protection and array-write path
`timescale 1ns/1ps
`include "smwpp_defines.svh"

module smwpp_top
  import smwpp_pkg::*;
(
  // System clock and resets
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic factory_rst_n,
  // Serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  // Array write monitor
  output logic mem_wr_pulse,
  output logic [`SMWPP_ADDR_W-1:0] mem_wr_addr,
  output logic [7:0] mem_wr_data,
  // Array read-back
  input wire logic [`SMWPP_ADDR_W-1:0] rd_addr,
  output logic [7:0] rd_data
);

  // ========================================================================
  // Declarations
  logic frame_clr;
  smwpp_state_t state;
  smwpp_state_t next_state;
  logic [2:0] bit_cnt;
  logic [6:0] rx_shift;
  logic [7:0] rx_byte;
  logic byte_done;
  logic [1:0] addr_cnt;
  logic [15:0] addr_acc;
  logic [23:0] addr_full;
  logic [`SMWPP_ADDR_W-1:0] addr;
  logic [`SMWPP_ADDR_W-1:0] next_addr;
  logic halted;
  logic write_ok;
  logic data_byte;
  logic [7:0] op_code;
  logic op_valid;
  logic write_enable_latch;
  logic protect_pin_enable;
  logic block_protect_hi;
  logic block_protect_lo;
  logic [7:0] protect_status;
  logic status_write_ok;
  logic wp_sync;
  logic [7:0] rd_shift;
  logic [`SMWPP_ADDR_W-1:0] wr_addr_l;
  logic [7:0] wr_data_l;
  logic wr_tgl;
  logic wr_tgl_s;
  logic wr_tgl_seen;
  logic mem_we;

  // ========================================================================
  // Frame framing
  // Everything scoped to one select cycle is cleared while select is high,
  // so a frame never inherits a half-counted bit or a stale state.
  assign frame_clr = cs_n | ~rst_n;

  assign rx_byte = {rx_shift, si};
  assign byte_done = (bit_cnt == `SMWPP_BIT_LAST);

  always_ff @(posedge sck or posedge frame_clr)
  begin
    if (frame_clr)
    begin
      bit_cnt <= `SMWPP_BIT_FIRST;
      rx_shift <= 7'h00;
    end
    else
    begin
      bit_cnt <= 3'(bit_cnt + 3'h1);
      rx_shift <= {rx_shift[5:0], si};
    end
  end

  // ========================================================================
  // Command state machine
  always_comb
  begin
    next_state = state;
    case (state)
      s_cmd: next_state = smwpp_decode(rx_byte);
      s_addr:
      begin
        if (addr_cnt == `SMWPP_ADDR_BYTE_LAST)
          next_state = s_data;
      end
      s_statw: next_state = s_done;
      s_ignore: next_state = s_ignore;
      default: next_state = state;
    endcase
  end

  always_ff @(posedge sck or posedge frame_clr)
  begin
    if (frame_clr)
      state <= s_cmd;
    else if (byte_done)
      state <= next_state;
  end

  // Last complete opcode, kept past the frame for the select-rise update.
  // Its valid flag is cleared on the first bit of a frame so a short frame counts for nothing.
  always_ff @(posedge sck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_code <= 8'h00;
      op_valid <= 1'b0;
    end
    else if (state == s_cmd && byte_done)
    begin
      op_code <= rx_byte;
      op_valid <= 1'b1;
    end
    else if (state == s_cmd && bit_cnt == `SMWPP_BIT_FIRST)
      op_valid <= 1'b0;
  end

  // ========================================================================
  // Write enable latch
  // Updated on the select rising edge; it then stays put for the whole
  // next frame, which makes it safe to read from the sck logic.
  always_ff @(posedge cs_n or negedge rst_n)
  begin
    if (!rst_n)
      write_enable_latch <= 1'b0;
    else if (op_valid)
    begin
      if (op_code == `SMWPP_OP_SET_LATCH)
        write_enable_latch <= 1'b1;
      else if (op_code == `SMWPP_OP_CLEAR_LATCH || op_code == `SMWPP_OP_STATUS_WRITE ||
               op_code == `SMWPP_OP_MEM_WRITE)
        write_enable_latch <= 1'b0;
    end
  end

  // ========================================================================
  // Nonvolatile status bits
  // Only the factory reset returns these to shipped values; ordinary
  // reset leaves them alone, as power loss would.
  smwpp_sync #(
    .RST_VAL(1'b1)
  ) u_wp_sync (
    .clk(sck),
    .rst_n(rst_n),
    .d(wp_n),
    .q(wp_sync)
  );

  assign status_write_ok = write_enable_latch & ~(protect_pin_enable & ~wp_sync);

  always_ff @(posedge sck or negedge factory_rst_n)
  begin
    if (!factory_rst_n)
    begin
      protect_pin_enable <= 1'b0;
      block_protect_hi <= 1'b0;
      block_protect_lo <= 1'b0;
    end
    else if (state == s_statw && byte_done && status_write_ok)
    begin
      protect_pin_enable <= rx_byte[`SMWPP_SR_PIN_EN];
      block_protect_hi <= rx_byte[`SMWPP_SR_BP_HI];
      block_protect_lo <= rx_byte[`SMWPP_SR_BP_LO];
    end
  end

  always_comb
  begin
    protect_status = `SMWPP_SR_FIXED;
    protect_status[`SMWPP_SR_PIN_EN] = protect_pin_enable;
    protect_status[`SMWPP_SR_BP_HI] = block_protect_hi;
    protect_status[`SMWPP_SR_BP_LO] = block_protect_lo;
    protect_status[1] = write_enable_latch;
  end

  // ========================================================================
  // Status read-out
  // The byte is loaded on the command's eighth rising edge and rotated,
  // so a master clocking on keeps reading the same status.
  always_ff @(posedge sck or posedge frame_clr)
  begin
    if (frame_clr)
      rd_shift <= 8'h00;
    else if (state == s_cmd && byte_done)
      rd_shift <= protect_status;
    else if (state == s_status_read_cmd)
      rd_shift <= {rd_shift[6:0], rd_shift[7]};
  end

  always_ff @(negedge sck or posedge frame_clr)
  begin
    if (frame_clr)
    begin
      so <= 1'b0;
      so_oe <= 1'b0;
    end
    else
    begin
      so_oe <= (state == s_status_read_cmd);
      so <= rd_shift[7];
    end
  end

  // ========================================================================
  // Address capture and burst
  assign addr_full = {addr_acc, rx_byte};
  assign data_byte = (state == s_data) && byte_done;
  // Protect pin deliberately absent from this term
  assign write_ok = write_enable_latch & ~halted &
                    ~smwpp_is_protected({block_protect_hi, block_protect_lo}, addr);
  assign next_addr = (addr == `SMWPP_ADDR_LAST) ? `SMWPP_ADDR_FIRST : (addr + `SMWPP_ADDR_ONE);

  always_ff @(posedge sck or posedge frame_clr)
  begin
    if (frame_clr)
    begin
      addr_cnt <= 2'h0;
      addr_acc <= 16'h0000;
      addr <= `SMWPP_ADDR_FIRST;
      halted <= 1'b0;
    end
    else if (state == s_addr && byte_done)
    begin
      addr_cnt <= 2'(addr_cnt + 2'h1);
      addr_acc <= addr_full[15:0];
      if (addr_cnt == `SMWPP_ADDR_BYTE_LAST)
        addr <= addr_full[`SMWPP_ADDR_W-1:0];
    end
    else if (data_byte)
    begin
      if (write_ok)
        addr <= next_addr;
      else
        halted <= 1'b1;
    end
  end

  // Committed byte held for the system side; stable for at least eight
  // sck periods, far longer than the toggle takes to cross.
  always_ff @(posedge sck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_addr_l <= `SMWPP_ADDR_FIRST;
      wr_data_l <= 8'h00;
      wr_tgl <= 1'b0;
    end
    else if (data_byte && write_ok)
    begin
      wr_addr_l <= addr;
      wr_data_l <= rx_byte;
      wr_tgl <= ~wr_tgl;
    end
  end

  // ========================================================================
  // System-side commit into the array
  smwpp_sync #(
    .RST_VAL(1'b0)
  ) u_wr_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d(wr_tgl),
    .q(wr_tgl_s)
  );

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      wr_tgl_seen <= 1'b0;
    else
      wr_tgl_seen <= wr_tgl_s;
  end

  assign mem_we = wr_tgl_s ^ wr_tgl_seen;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_wr_pulse <= 1'b0;
      mem_wr_addr <= `SMWPP_ADDR_FIRST;
      mem_wr_data <= 8'h00;
    end
    else
    begin
      mem_wr_pulse <= mem_we;
      if (mem_we)
      begin
        mem_wr_addr <= wr_addr_l;
        mem_wr_data <= wr_data_l;
      end
    end
  end

  smwpp_ram u_ram (
    .clk(sys_clk),
    .rst_n(rst_n),
    .we(mem_we),
    .wr_addr(wr_addr_l),
    .wr_data(wr_data_l),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

endmodule : smwpp_top

/* File: bench/smwpp_mst.sv */
// SPI master model for the serial link of the write-protect path
`timescale 1ns/1ps
module smwpp_mst (
  // Serial link
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic wp_n,
  input wire logic so,
  input wire logic so_oe
);
  logic [7:0] junk;
  logic miso;
  // Released line sits at its pull-up level
  assign miso = so_oe ? so : 1'h1;
  initial
  begin
    sck = 1'h0;
    cs_n = 1'h1;
    si = 1'h1;
    wp_n = 1'h1;
  end
  // ==========================================================
  // Bus cycles, mode 0: sck stands low between frames
  // Odd lead-in keeps sck edges off the system clock grid
  task automatic sel();
    cs_n = 1'h0;
    #6.3;
  endtask : sel
  // Deselect gap well above one system cycle
  task automatic desel();
    #6 cs_n = 1'h1;
    #30;
  endtask : desel
  // MSB first; n below 8 leaves a partial byte
  task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] q);
    q = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      si = d[i];
      #6 sck = 1'h1;
      q[i] = miso;
      #6 sck = 1'h0;
    end
    si = ~si;
  endtask : xfer
  task automatic cmd(input logic [7:0] op);
    sel();
    xfer(op, 8, junk);
    desel();
  endtask : cmd
  task automatic status_write_cmd(input logic [7:0] v);
    cmd(8'h06);
    sel();
    xfer(8'h01, 8, junk);
    xfer(v, 8, junk);
    desel();
  endtask : status_write_cmd
  task automatic status_read_cmd(output logic [7:0] v);
    sel();
    xfer(8'h05, 8, junk);
    xfer(8'h00, 8, v);
    desel();
  endtask : status_read_cmd
  // Upper six address bits sent nonzero so that they must be dropped
  task automatic wr_head(input logic [17:0] a, input logic en);
    if (en)
      cmd(8'h06);
    sel();
    xfer(8'h02, 8, junk);
    xfer({6'h2A, a[17:16]}, 8, junk);
    xfer(a[15:8], 8, junk);
    xfer(a[7:0], 8, junk);
  endtask : wr_head
endmodule : smwpp_mst

/* File: bench/smwpp_assertions.sv */
// Concurrent checks on the ports of the write-protect path
`timescale 1ns/1ps
`include "smwpp_defines.svh"
module smwpp_assertions (
  // Clocks and resets
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic factory_rst_n,
  // Serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  input wire logic so,
  input wire logic so_oe,
  // Array write monitor and read-back
  input wire logic mem_wr_pulse,
  input wire logic [`SMWPP_ADDR_W-1:0] mem_wr_addr,
  input wire logic [7:0] mem_wr_data,
  input wire logic [`SMWPP_ADDR_W-1:0] rd_addr,
  input wire logic [7:0] rd_data
);
  logic [7:0] bit_cnt = 8'h00;
  logic [7:0] op_sh;
  logic [7:0] gap;
  logic [`SMWPP_ADDR_W-1:0] last_addr;
  // ==========================================================
  // Frame bit count, cleared while deselected, and opcode shifted from the first eight bits
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
      bit_cnt <= 8'h00;
    else if (bit_cnt != 8'hFF)
      bit_cnt <= bit_cnt + 8'h01;
  end
  always_ff @(posedge sck)
  begin
    if (!cs_n && bit_cnt < 8'h08)
      op_sh <= {op_sh[6:0], si};
  end
  // Bytes of one burst commit about 19 cycles apart, frames far more
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gap <= 8'hFF;
      last_addr <= '0;
    end
    else if (mem_wr_pulse)
    begin
      gap <= 8'h00;
      last_addr <= mem_wr_addr;
    end
    else if (gap != 8'hFF)
      gap <= gap + 8'h01;
  end
  sequence s_commit_here;
    mem_wr_pulse && rd_addr == mem_wr_addr;
  endsequence
  // ==========================================================
  // Checks
  chk_oe_deselect: assert property (@(posedge sys_clk) disable iff (!rst_n) cs_n |-> !so_oe)
    else $error("so_oe high while deselected");
  chk_pulse_single: assert property (@(posedge sys_clk) disable iff (!rst_n) mem_wr_pulse |=> !mem_wr_pulse)
    else $error("commit pulse longer than one cycle");
  chk_addr_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) !$stable(mem_wr_addr) |-> mem_wr_pulse)
    else $error("commit address moved without a commit");
  chk_seq_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mem_wr_pulse && gap < 8'h28 |-> mem_wr_addr == last_addr + 18'h00001)
    else $error("burst address not consecutive");
  chk_read_back: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_commit_here |=> rd_data == $past(mem_wr_data))
    else $error("committed byte not in array");
  chk_oe_opcode: assert property (@(posedge sck) disable iff (!rst_n)
    so_oe |-> bit_cnt >= 8'h08 && op_sh == 8'h05)
    else $error("output driven outside status read");
  chk_fixed_one: assert property (@(posedge sck) disable iff (!rst_n) so_oe && bit_cnt[2:0] == 3'h1 |-> so)
    else $error("status bit 6 not one");
  chk_fixed_zero: assert property (@(posedge sck) disable iff (!rst_n)
    so_oe && bit_cnt[2:0] inside {3'h2, 3'h3, 3'h7} |-> !so)
    else $error("fixed zero status bit not zero");
endmodule : smwpp_assertions
bind smwpp_top smwpp_assertions smwpp_assertions_inst (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .factory_rst_n(factory_rst_n),
  .sck(sck),
  .cs_n(cs_n),
  .si(si),
  .wp_n(wp_n),
  .so(so),
  .so_oe(so_oe),
  .mem_wr_pulse(mem_wr_pulse),
  .mem_wr_addr(mem_wr_addr),
  .mem_wr_data(mem_wr_data),
  .rd_addr(rd_addr),
  .rd_data(rd_data)
);

/* File: bench/test_spi_memory_write_protect_path.sv */
// Self-checking bench of the write-protect and array-write path
`timescale 1ns/1ps
module test_spi_memory_write_protect_path;
  typedef struct packed {
    logic [1:0] bp;
    logic [17:0] a;
    logic ok;
  } smwpp_row_t;
  logic sys_clk = 1'h0;
  // Held in reset from time zero so no edge sees an unknown reset level
  logic rst_n = 1'h0;
  logic factory_rst_n = 1'h0;
  logic [17:0] rd_addr;
  logic [7:0] r;
  // Nets driven by the block and by the master model
  wire logic sck, cs_n, si, wp_n, so, so_oe, mem_wr_pulse;
  wire logic [17:0] mem_wr_addr;
  wire logic [7:0] rd_data, mem_wr_data;
  int fails = 0;
  int total_checks = 0;
  int pulses = 0;
  int p0;
  smwpp_row_t rows [6] = '{'{2'h0, 18'h3FFFF, 1'h1}, '{2'h1, 18'h2FFFF, 1'h1}, '{2'h1, 18'h30000, 1'h0},
    '{2'h2, 18'h1FFFF, 1'h1}, '{2'h2, 18'h20000, 1'h0}, '{2'h3, 18'h00000, 1'h0}};
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (mem_wr_pulse === 1'h1)
      pulses++;
  smwpp_top smwpp_top_inst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .factory_rst_n(factory_rst_n),
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .wp_n(wp_n),
    .so(so),
    .so_oe(so_oe),
    .mem_wr_pulse(mem_wr_pulse),
    .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );
  smwpp_mst smwpp_mst_inst (
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .wp_n(wp_n),
    .so(so),
    .so_oe(so_oe)
  );
  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic stat(input logic [7:0] exp);
    smwpp_mst_inst.status_read_cmd(r);
    check("status", r, exp);
  endtask : stat
  task automatic peek(input logic [17:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    rd_addr = a;
    repeat (2) @(negedge sys_clk);
    check("array", rd_data, exp);
  endtask : peek
  task automatic open(input logic [17:0] a, input logic en);
    @(negedge sys_clk);
    rd_addr = a;
    smwpp_mst_inst.wr_head(a, en);
  endtask : open
  // Commit lands a few system cycles after the eighth bit
  task automatic close();
    smwpp_mst_inst.desel();
    repeat (8) @(negedge sys_clk);
  endtask : close
  task automatic wr1(input logic [17:0] a, input logic [7:0] d);
    open(a, 1'h1);
    smwpp_mst_inst.xfer(d, 8, r);
    close();
  endtask : wr1
  task automatic pulse_rst(input logic f);
    @(negedge sys_clk);
    rst_n = 1'h0;
    factory_rst_n = !f;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'h1;
    factory_rst_n = 1'h1;
    repeat (3) @(negedge sys_clk);
  endtask : pulse_rst
  // ==========================================================
  // Main sequence
  initial
  begin
    rd_addr = 18'h00000;
    pulse_rst(1'h1);
    stat(8'h40);
    foreach (rows[i])
    begin
      smwpp_mst_inst.status_write_cmd(8'h00);
      wr1(rows[i].a, 8'hA5);
      smwpp_mst_inst.status_write_cmd({4'h0, rows[i].bp, 2'h0});
      stat({4'h4, rows[i].bp, 2'h0});
      wr1(rows[i].a, 8'h3C);
      peek(rows[i].a, rows[i].ok ? 8'h3C : 8'hA5);
    end
    smwpp_mst_inst.cmd(8'h06);
    pulse_rst(1'h0);
    stat(8'h4C);
    pulse_rst(1'h1);
    smwpp_mst_inst.cmd(8'h06);
    stat(8'h42);
    smwpp_mst_inst.status_write_cmd(8'hFF);
    stat(8'hCC);
    smwpp_mst_inst.status_write_cmd(8'h80);
    smwpp_mst_inst.wp_n = 1'h0;
    smwpp_mst_inst.status_write_cmd(8'h04);
    stat(8'hC0);
    wr1(18'h3FFFF, 8'h77);
    peek(18'h3FFFF, 8'h77);
    smwpp_mst_inst.wp_n = 1'h1;
    smwpp_mst_inst.status_write_cmd(8'h00);
    smwpp_mst_inst.wp_n = 1'h0;
    smwpp_mst_inst.status_write_cmd(8'h04);
    stat(8'h44);
    smwpp_mst_inst.wp_n = 1'h1;
    // Status byte cut after four bits
    smwpp_mst_inst.cmd(8'h06);
    smwpp_mst_inst.sel();
    smwpp_mst_inst.xfer(8'h01, 8, r);
    smwpp_mst_inst.xfer(8'h88, 4, r);
    smwpp_mst_inst.desel();
    stat(8'h44);
    p0 = pulses;
    open(18'h2FFFF, 1'h1);
    smwpp_mst_inst.xfer(8'h61, 8, r);
    smwpp_mst_inst.xfer(8'h62, 8, r);
    smwpp_mst_inst.xfer(8'h63, 8, r);
    close();
    check("pulses", 8'(pulses - p0), 8'h01);
    peek(18'h2FFFF, 8'h61);
    smwpp_mst_inst.status_write_cmd(8'h00);
    wr1(18'h00010, 8'h99);
    smwpp_mst_inst.cmd(8'h06);
    smwpp_mst_inst.cmd(8'h04);
    stat(8'h40);
    open(18'h00010, 1'h0);
    smwpp_mst_inst.xfer(8'h55, 8, r);
    close();
    peek(18'h00010, 8'h99);
    p0 = pulses;
    open(18'h3FFFE, 1'h1);
    smwpp_mst_inst.xfer(8'h11, 8, r);
    smwpp_mst_inst.xfer(8'h22, 8, r);
    smwpp_mst_inst.xfer(8'h33, 8, r);
    smwpp_mst_inst.xfer(8'h44, 5, r);
    close();
    check("pulses", 8'(pulses - p0), 8'h03);
    peek(18'h00000, 8'h33);
    smwpp_mst_inst.sel();
    smwpp_mst_inst.xfer(8'hAB, 8, r);
    smwpp_mst_inst.xfer(8'h05, 8, r);
    smwpp_mst_inst.desel();
    check("idle so", r, 8'hFF);
    stop_test();
  end
  // Hang guard
  initial
  begin
    #400000;
    fails++;
    stop_test();
  end
endmodule : test_spi_memory_write_protect_path
